//--- rivg_pkg.sv
package rivg_pkg;
   // ---------------------------------------------------------------
   // Address widths and table constants
   // ---------------------------------------------------------------
   localparam int ADDR_W = 16;
   localparam int IDX_W = 5;
   localparam logic [15:0] RESET_ADDR = 16'h0000;
   localparam logic [15:0] TABLE_OFS = 16'h0002;
   localparam logic [15:0] VEC_SPACING = 16'h0002;
   localparam logic [4:0] FULL_COUNT = 5'h1c;
   localparam logic [4:0] COMPAT_COUNT = 5'h16;
   localparam logic [15:0] FULL_LAST = 16'h0036;
   localparam logic [15:0] COMPAT_LAST = 16'h002a;
   localparam logic [4:0] RESET_VEC_NO = 5'h01;
   localparam logic [1:0] SYNC_ONES = 2'h3;
   localparam logic FUSE_PROGRAMMED = 1'b0;

   // Source numbering, full map order (vector number minus one)
   typedef enum logic [4:0] {
      SRC_RESET = 5'h00, SRC_EXT0 = 5'h01, SRC_EXT1 = 5'h02, SRC_EXT2 = 5'h03,
      SRC_PCA = 5'h04, SRC_PCB = 5'h05, SRC_T3_CAPT = 5'h06, SRC_T3_CMPA = 5'h07,
      SRC_T3_CMPB = 5'h08, SRC_T3_OVF = 5'h09, SRC_T2_CMP = 5'h0a, SRC_T2_OVF = 5'h0b,
      SRC_T1_CAPT = 5'h0c, SRC_T1_CMPA = 5'h0d, SRC_T1_CMPB = 5'h0e, SRC_T1_OVF = 5'h0f,
      SRC_T0_CMP = 5'h10, SRC_T0_OVF = 5'h11, SRC_SPI = 5'h12, SRC_RX0 = 5'h13,
      SRC_RX1 = 5'h14, SRC_TXE0 = 5'h15, SRC_TXE1 = 5'h16, SRC_TX0 = 5'h17,
      SRC_TX1 = 5'h18, SRC_NV = 5'h19, SRC_ACMP = 5'h1a, SRC_PSTORE = 5'h1b
   } rivg_src_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_RESET = 2'b01,
      ST_RUN = 2'b11
   } rivg_state_t;

   // Static configuration from fuses and control bits
   typedef struct packed {
      logic boot_reset_fuse;
      logic compat_map_fuse;
      logic vector_table_select;
      logic [15:0] boot_addr;
   } rivg_cfg_t;

   // Request from the core
   typedef struct packed {
      logic ack;
      logic [4:0] src;
   } rivg_req_t;

   // Answer to the core
   typedef struct packed {
      logic valid;
      logic is_reset;
      logic [15:0] addr;
      logic [4:0] slot;
   } rivg_vec_t;
endpackage

//--- rivg_slot_map.sv
`timescale 1ns/1ps
// Translates a full-map source into its slot in the active map
module rivg_slot_map (
   input wire logic compat,
   input wire rivg_pkg::rivg_src_t src,
   output logic [4:0] slot,
   output logic valid
);
   import rivg_pkg::*;

   // ---------------------------------------------------------------
   // Compatibility remap
   // ---------------------------------------------------------------
   // Pin-change and timer 3 slots do not exist in the reduced map
   wire is_gap = (src >= SRC_PCA) && (src <= SRC_T3_OVF);
   wire is_low = (src <= SRC_EXT2);
   wire [4:0] shifted = 5'(src - 5'h06);
   wire [4:0] slot_compat = is_low ? src : shifted;
   wire in_full = (src < FULL_COUNT);

   assign slot = compat ? slot_compat : src;
   assign valid = in_full && !(compat && is_gap);
endmodule

//--- rivg_vector_gen.sv
`timescale 1ns/1ps

module rivg_vector_gen (
   mclk,
   rst_n,
   clk_en,
   cfg,
   reset_cause,
   req,
   vec
);
   import rivg_pkg::*;

   input wire logic mclk;
   input wire logic rst_n;
   input wire logic clk_en;
   input wire rivg_pkg::rivg_cfg_t cfg;
   input wire logic [4:0] reset_cause;
   input wire rivg_pkg::rivg_req_t req;
   output rivg_pkg::rivg_vec_t vec;

   // ---------------------------------------------------------------
   // Reset release
   // ---------------------------------------------------------------
   logic [1:0] rst_sync_q;
   logic srst_n;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rst_sync_q <= 2'h0;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign srst_n = rst_sync_q[1];

   // ---------------------------------------------------------------
   // Address selection
   // ---------------------------------------------------------------
   logic [4:0] slot;
   logic slot_valid;
   logic [15:0] reset_addr;
   logic [15:0] table_base;
   logic [15:0] irq_addr;
   logic any_cause;
   logic take_irq;

   rivg_slot_map u_map (
      .compat(cfg.compat_map_fuse == FUSE_PROGRAMMED),
      .src(rivg_src_t'(req.src)),
      .slot(slot),
      .valid(slot_valid)
   );

   // Boot address supplied from boot-size settings
   assign reset_addr = (cfg.boot_reset_fuse == FUSE_PROGRAMMED) ? cfg.boot_addr : RESET_ADDR;
   // Base does not depend on the boot fuse
   assign table_base = cfg.vector_table_select ? 16'(cfg.boot_addr + TABLE_OFS) : TABLE_OFS;
   // Spacing is kept, only the base moves
   assign irq_addr = 16'(table_base + VEC_SPACING * 16'(slot - 5'h01));
   // Every cause of reset funnels into one entry
   assign any_cause = |reset_cause;
   // Reset slot is never taken as an interrupt
   assign take_irq = req.ack && slot_valid && (req.src != SRC_RESET);

   // ---------------------------------------------------------------
   // Sequencer
   // ---------------------------------------------------------------
   rivg_state_t state_q;
   rivg_state_t state_d;
   rivg_vec_t vec_q;
   rivg_vec_t vec_d;

   always_comb begin
      state_d = state_q;
      vec_d = vec_q;
      vec_d.valid = 1'b0;
      case (state_q)
         ST_IDLE: begin
            state_d = ST_RESET;
         end
         ST_RESET: begin
            vec_d.valid = 1'b1;
            vec_d.is_reset = 1'b1;
            vec_d.addr = reset_addr;
            vec_d.slot = RESET_VEC_NO;
            state_d = ST_RUN;
         end
         ST_RUN: begin
            if (any_cause) begin
               state_d = ST_RESET;
            end else if (take_irq) begin
               vec_d.valid = 1'b1;
               vec_d.is_reset = 1'b0;
               vec_d.addr = irq_addr;
               vec_d.slot = 5'(slot + RESET_VEC_NO);
            end
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
   end

   // Reset clears to the reset-state configuration
   always_ff @(posedge mclk or negedge srst_n) begin
      if (!srst_n) begin
         state_q <= ST_IDLE;
         vec_q <= '0;
      end else if (clk_en) begin
         state_q <= state_d;
         vec_q <= vec_d;
      end
   end

   assign vec = vec_q;
endmodule

//--- rivg_core_model.sv
`timescale 1ns/1ps
// Core side: one acknowledge per command, index wanders while idle
module rivg_core_model (
   input logic mclk,
   input logic go,
   input logic [4:0] s,
   output rivg_pkg::rivg_req_t req
);
   import rivg_pkg::*;
   always_ff @(posedge mclk) begin
      req <= '{go, go ? s : ~req.src};
   end
endmodule

//--- rivg_vector_gen_sva.sv
`timescale 1ns/1ps
module rivg_check (
   input logic mclk,
   input logic rst_n,
   input logic clk_en,
   input rivg_pkg::rivg_cfg_t cfg,
   input logic [4:0] reset_cause,
   input rivg_pkg::rivg_req_t req,
   input rivg_pkg::rivg_vec_t vec
);
   import rivg_pkg::*;
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   reset_addr_a: assert property (vec.valid && vec.is_reset |-> vec.slot == 5'h01 &&
      vec.addr == (cfg.boot_reset_fuse ? 16'h0000 : cfg.boot_addr)) else $error("reset vector");
   table_base_a: assert property (vec.valid && !vec.is_reset |-> vec.addr ==
      (cfg.vector_table_select ? cfg.boot_addr : 16'h0000) + {10'h000, vec.slot, 1'b0} - 16'h0002)
      else $error("vector base");
   slot_map_a: assert property (vec.valid && !vec.is_reset |-> vec.slot == (!cfg.compat_map_fuse &&
      $past(req.src) > 5'h03 ? $past(req.src) - 5'h05 : $past(req.src) + 5'h01)) else $error("slot");
   compat_count_a: assert property (vec.valid && !cfg.compat_map_fuse |-> vec.slot <= 5'h16)
      else $error("compat slot");
   full_count_a: assert property (vec.valid |-> vec.slot inside {[5'h01:5'h1c]}) else $error("slot range");
   taken_only_a: assert property (vec.valid && !vec.is_reset |-> $past(req.ack)) else $error("no ack");
   compat_gap_a: assert property (req.ack && !cfg.compat_map_fuse && req.src inside {[5'h04:5'h09]}
      |=> !vec.valid) else $error("gap answered");
   cause_reset_a: assert property ($rose(|reset_cause) |-> ##2 vec.valid && vec.is_reset) else $error("cause");
endmodule

//--- testbench.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin fails++; $display("wrong value %s %h %h", n, e, g); end end
module testbench;
   import rivg_pkg::*;
   logic mclk = 0, rst_n = 0, go = 0, ce = 1;
   logic [4:0] s = 0, cause = 0;
   rivg_cfg_t cfg = '{1'b1, 1'b1, 1'b0, 16'h1c00};
   rivg_req_t req;
   rivg_vec_t vec;
   int fails = 0, compares = 0, cyc = 0;
   always #12.5 mclk = ~mclk;
   rivg_vector_gen rivg_vector_gen_inst (.mclk(mclk), .rst_n(rst_n), .clk_en(ce), .cfg(cfg),
      .reset_cause(cause), .req(req), .vec(vec));
   rivg_core_model rivg_core_model_inst (.mclk(mclk), .go(go), .s(s), .req(req));
   task automatic end_of_test();
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // Whole run is near 420 cycles
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 1000) begin
         fails++;
         end_of_test();
      end
   end
   task automatic t_reset(input logic f);
      int n = 0;
      @(posedge mclk);
      rst_n <= 0;
      cfg.boot_reset_fuse <= f;
      repeat (20) @(posedge mclk);
      rst_n <= 1;
      while (vec.valid !== 1'b1 && n++ < 20) @(posedge mclk) #1;
      `CHK("reset", {2'b11, f ? 16'h0000 : 16'h1c00}, {vec.valid, vec.is_reset, vec.addr})
      $display("reset done");
   endtask
   task automatic t_map(input logic cm, input logic vt);
      logic [15:0] e;
      @(posedge mclk);
      cfg.compat_map_fuse <= cm;
      cfg.vector_table_select <= vt;
      for (int i = 1; i < 28; i++) begin
         @(posedge mclk);
         go <= 1;
         s <= 5'(i);
         @(posedge mclk);
         go <= 0;
         @(posedge mclk) #1;
         e = (vt ? 16'h1c00 : 16'h0000) + 16'(cm || i < 4 ? 2 * i : 2 * i - 12);
         if (!cm && i > 3 && i < 10) `CHK("gap", 1'b0, vec.valid)
         else `CHK("vector", {1'b1, e}, {vec.valid, vec.addr})
      end
      $display("map done");
   endtask
   // Acknowledge while the clock enable is low must leave the answer frozen
   task automatic t_freeze();
      @(posedge mclk);
      ce <= 0;
      go <= 1;
      s <= 5'h01;
      @(posedge mclk);
      go <= 0;
      @(posedge mclk) #1;
      `CHK("freeze", 1'b0, vec.valid)
      @(posedge mclk);
      ce <= 1;
      repeat (2) @(posedge mclk);
      $display("freeze done");
   endtask
   task automatic t_cause();
      for (int b = 0; b < 5; b++) begin
         @(posedge mclk);
         cause <= 5'(5'h01 << b);
         @(posedge mclk);
         cause <= 5'h00;
         @(posedge mclk) #1;
         `CHK("cause", 18'h31c00, {vec.valid, vec.is_reset, vec.addr})
         repeat (4) @(posedge mclk);
      end
      $display("cause done");
   endtask
   initial begin
      t_reset(1'b1);
      for (int c = 0; c < 4; c++) t_map(c[1], c[0]);
      t_freeze();
      t_reset(1'b0);
      t_cause();
      end_of_test();
   end
endmodule
bind rivg_vector_gen rivg_check rivg_check_inst (.mclk(mclk), .rst_n(rst_n), .clk_en(clk_en), .cfg(cfg),
   .reset_cause(reset_cause), .req(req), .vec(vec));
